// >>> core/toc_pkg.sv
package toc_pkg;

  // ==========================================================================
  // Widths and constants
  localparam int unsigned POT_W = 8;
  localparam int unsigned LVL_W = 8;
  localparam int unsigned CHG_W = 7;
  localparam int unsigned HOUR_W = 32;
  localparam logic [CHG_W-1:0] CHARGE_ALARM_PCT = 7'h0A;
  localparam logic [6:0] SPEED_CAP_PCT = 7'h0A;
  localparam logic [6:0] SPEED_FULL_PCT = 7'h64;
  localparam logic [POT_W-1:0] POT_MIN_RST = 8'h00;
  localparam logic [POT_W-1:0] POT_SPAN_MIN = 8'h01;
  localparam logic [HOUR_W-1:0] HOURS_RST = 32'h0000_0000;
  localparam logic [15:0] AUX_TIME_RST = 16'h0000;

  // ==========================================================================
  // Option encodings
  typedef enum logic [1:0] {
    TOC_AUX_BRAKE = 2'h0,
    TOC_AUX_HYDRO = 2'h1,
    TOC_AUX_EXCL = 2'h2
  } toc_aux_t;

  typedef enum logic [1:0] {
    TOC_TEMP_DIGITAL = 2'h0,
    TOC_TEMP_ANALOG = 2'h1,
    TOC_TEMP_NONE = 2'h2
  } toc_temp_t;

  typedef enum logic [1:0] {
    TOC_RAMP_IDLE = 2'h0,
    TOC_RAMP_HOLD = 2'h1,
    TOC_RAMP_DONE = 2'h3
  } toc_ramp_t;

  // ==========================================================================
  // Programmed options
  typedef struct packed {
    logic count_key_on;
    logic battery_check;
    logic cutback_present;
    logic hydro_key_on;
    logic stop_on_ramp;
    toc_aux_t aux_sel;
    logic pedal_analog;
    toc_temp_t temp_sel;
    logic aux_function;
    logic enable_present;
    logic check_pump;
    logic combi_system;
  } toc_opt_t;

  // Raw switch pins, sampled through synchronisers
  typedef struct packed {
    logic mode_tied_low;
    logic key_closed;
    logic safety_tied_low;
    logic fwd;
    logic bwd;
    logic brake_sw;
    logic shared_e14;
    logic shared_f10;
    logic lift_permit_input;
    logic [3:0] speed_step_request;
    logic steer_req;
    logic motor_thermal_input;
  } toc_pins_t;

endpackage : toc_pkg

// >>> core/toc_core.sv
// What this block does
// - Open mode pin traction, tied low pump
// - Pump: lift permit, speeds active high
// - Pump: speed reduction active when low
// - Pump: steering request active high
// - Safety not tied low disables contactor
// - Pump aux output: contactor alone, off in combi
// - Hours count travel or key closed
// - Check on: alarm, half current at 10%
// - Check off: compute charge, no alarm
// - Traction F10: cutback or handbrake by option
// - Key-on steering with hydro aux options
// - Ramp hold for aux time, then aux
// - Brake option: aux output drives brake
// - Hydro option: steer on direction, brake, motion
// - Exclusive option: steer on exclusive input
// - Analog braking linear from minimum to maximum
// - Digital braking uses pedal braking level
// - Temperature: switch, analog sensor or none
// - Aux function: maximum braking and traction
// - Traction E14: enable or exclusive hydro
// - Lost pump messages: warning, 10% speed
// - Brake minimum stores pot with switch closed
`timescale 1ns/1ps
`default_nettype none
module toc_core #(
  parameter int unsigned AUX_TIME_W = 16
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire toc_pkg::toc_pins_t PINS_I,
  input wire toc_pkg::toc_opt_t OPT_I,
  input wire logic [AUX_TIME_W-1:0] AUX_TIME_I,
  input wire logic MOVING_I,
  input wire logic ON_SLOPE_I,
  input wire logic ACCEL_RELEASED_I,
  input wire logic [toc_pkg::POT_W-1:0] BRAKE_POT_I,
  input wire logic [toc_pkg::POT_W-1:0] BRAKE_POT_MAX_I,
  input wire logic [toc_pkg::LVL_W-1:0] RELEASE_BRAKE_LVL_I,
  input wire logic [toc_pkg::LVL_W-1:0] PEDAL_BRAKE_LVL_I,
  input wire logic [toc_pkg::CHG_W-1:0] CHARGE_PCT_I,
  input wire logic CAL_BRAKE_MIN_I,
  input wire logic PUMP_MSG_SEEN_I,
  input wire logic PUMP_ALARM_I,
  output logic PUMP_MODE_O,
  output logic MAIN_COIL_EN_O,
  output logic SAFETY_GP_O,
  output logic AUX_LOW_SIDE_O,
  output logic STEERING_CONTACTOR_O,
  output logic STEER_REQ_CAN_O,
  output logic LIFT_PERMIT_O,
  output logic [3:0] SPEED_STEP_O,
  output logic SPEED_REDUCE_O,
  output logic HANDBRAKE_O,
  output logic ACCEL_ENABLE_O,
  output logic [toc_pkg::HOUR_W-1:0] HOURS_O,
  output logic BATTERY_ALARM_O,
  output logic HALF_CURRENT_O,
  output logic RAMP_HOLD_O,
  output logic BRAKING_ON_O,
  output logic [toc_pkg::LVL_W-1:0] BRAKE_LEVEL_O,
  output logic [toc_pkg::POT_W-1:0] BRAKE_POT_MIN_O,
  output logic THERMAL_SWITCH_USE_O,
  output logic THERMAL_ANALOG_USE_O,
  output logic MAX_TORQUE_O,
  output logic BUS_FAILURE_WARNING_O,
  output logic [6:0] SPEED_LIMIT_PCT_O
);
  import toc_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  toc_pins_t sync1_ff, sync2_ff;
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= PINS_I;
      sync2_ff <= sync1_ff;
    end
  end

  // ==========================================================================
  // Input interpretation
  logic pump, excl_in, steer_on;
  logic [HOUR_W-1:0] hours_ff, nxt_hours;
  logic [POT_W-1:0] pmin_ff, nxt_pmin;
  toc_ramp_t ramp_ff, nxt_ramp;
  logic [AUX_TIME_W-1:0] rcnt_ff, nxt_rcnt;
  logic [LVL_W-1:0] lvl_c;
  logic [POT_W-1:0] span, pos;
  logic [POT_W+LVL_W-1:0] prod;

  assign pump = sync2_ff.mode_tied_low;
  assign excl_in = !pump && !OPT_I.enable_present && sync2_ff.shared_e14;

  always_comb begin
    steer_on = 1'b0;
    if (pump) begin
      steer_on = sync2_ff.steer_req;
    end else begin
      unique case (OPT_I.aux_sel)
        TOC_AUX_HYDRO: steer_on = sync2_ff.fwd || sync2_ff.bwd ||
          sync2_ff.brake_sw || MOVING_I;
        TOC_AUX_EXCL: steer_on = excl_in;
        default: steer_on = 1'b0;
      endcase
      // Key-on steering only exists with a contactor on the aux output
      if (OPT_I.hydro_key_on && sync2_ff.key_closed &&
          OPT_I.aux_sel != TOC_AUX_BRAKE) begin
        steer_on = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Runtime_count_option, ramp hold, brake minimum
  always_comb begin
    nxt_hours = hours_ff;
    if (OPT_I.count_key_on ? sync2_ff.key_closed : MOVING_I) begin
      nxt_hours = hours_ff + HOUR_W'(1);
    end
    nxt_pmin = pmin_ff;
    if (CAL_BRAKE_MIN_I && sync2_ff.brake_sw) begin
      nxt_pmin = BRAKE_POT_I;
    end
    // Hold time counts clock cycles; any prescaling sits outside
    nxt_ramp = ramp_ff;
    nxt_rcnt = rcnt_ff;
    unique case (ramp_ff)
      TOC_RAMP_IDLE: begin
        if (OPT_I.stop_on_ramp && ON_SLOPE_I && !pump) begin
          nxt_ramp = TOC_RAMP_HOLD;
          nxt_rcnt = AUX_TIME_I;
        end
      end
      TOC_RAMP_HOLD: begin
        if (!ON_SLOPE_I || !OPT_I.stop_on_ramp) begin
          nxt_ramp = TOC_RAMP_IDLE;
        end else if (rcnt_ff == '0) begin
          nxt_ramp = TOC_RAMP_DONE;
        end else begin
          nxt_rcnt = rcnt_ff - AUX_TIME_W'(1);
        end
      end
      TOC_RAMP_DONE: begin
        if (!ON_SLOPE_I) begin
          nxt_ramp = TOC_RAMP_IDLE;
        end
      end
      default: nxt_ramp = TOC_RAMP_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hours_ff <= HOURS_RST;
      pmin_ff <= POT_MIN_RST;
      ramp_ff <= TOC_RAMP_IDLE;
      rcnt_ff <= AUX_TIME_W'(AUX_TIME_RST);
    end else begin
      hours_ff <= nxt_hours;
      pmin_ff <= nxt_pmin;
      ramp_ff <= nxt_ramp;
      rcnt_ff <= nxt_rcnt;
    end
  end

  // ==========================================================================
  // Braking level: linear between release minimum and pedal maximum
  always_comb begin
    span = (BRAKE_POT_MAX_I > pmin_ff) ? BRAKE_POT_MAX_I - pmin_ff :
      POT_SPAN_MIN;
    pos = (BRAKE_POT_I > pmin_ff) ? BRAKE_POT_I - pmin_ff : '0;
    if (pos > span) begin
      pos = span;
    end
    prod = (PEDAL_BRAKE_LVL_I > RELEASE_BRAKE_LVL_I) ?
      (POT_W+LVL_W)'(pos) * (POT_W+LVL_W)'(PEDAL_BRAKE_LVL_I -
      RELEASE_BRAKE_LVL_I) : '0;
    lvl_c = OPT_I.pedal_analog ?
      RELEASE_BRAKE_LVL_I + LVL_W'(prod / (POT_W+LVL_W)'(span))
      : PEDAL_BRAKE_LVL_I;
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PUMP_MODE_O <= 1'b0;
      MAIN_COIL_EN_O <= 1'b0;
      SAFETY_GP_O <= 1'b0;
      AUX_LOW_SIDE_O <= 1'b0;
      STEERING_CONTACTOR_O <= 1'b0;
      STEER_REQ_CAN_O <= 1'b0;
      LIFT_PERMIT_O <= 1'b0;
      SPEED_STEP_O <= 4'h0;
      SPEED_REDUCE_O <= 1'b0;
      HANDBRAKE_O <= 1'b0;
      ACCEL_ENABLE_O <= 1'b0;
      BATTERY_ALARM_O <= 1'b0;
      HALF_CURRENT_O <= 1'b0;
      BRAKING_ON_O <= 1'b0;
      BRAKE_LEVEL_O <= '0;
      THERMAL_SWITCH_USE_O <= 1'b0;
      THERMAL_ANALOG_USE_O <= 1'b0;
      MAX_TORQUE_O <= 1'b0;
      BUS_FAILURE_WARNING_O <= 1'b0;
      SPEED_LIMIT_PCT_O <= SPEED_FULL_PCT;
    end else begin
      PUMP_MODE_O <= pump;
      MAIN_COIL_EN_O <= sync2_ff.safety_tied_low;
      SAFETY_GP_O <= sync2_ff.safety_tied_low;
      // Pump: alone it switches the contactor, combi holds it off
      AUX_LOW_SIDE_O <= pump ? (OPT_I.combi_system ? 1'b0 :
        sync2_ff.safety_tied_low) :
        (OPT_I.aux_sel == TOC_AUX_BRAKE &&
        ramp_ff != TOC_RAMP_HOLD && (MOVING_I || sync2_ff.fwd ||
        sync2_ff.bwd));
      STEERING_CONTACTOR_O <= steer_on;
      STEER_REQ_CAN_O <= !pump && steer_on;
      LIFT_PERMIT_O <= pump && sync2_ff.lift_permit_input;
      SPEED_STEP_O <= pump ? sync2_ff.speed_step_request : 4'h0;
      SPEED_REDUCE_O <= pump ? !sync2_ff.shared_f10 :
        (OPT_I.cutback_present && !sync2_ff.shared_f10);
      HANDBRAKE_O <= !pump && !OPT_I.cutback_present &&
        !sync2_ff.shared_f10;
      ACCEL_ENABLE_O <= pump || !OPT_I.enable_present ||
        sync2_ff.shared_e14;
      BATTERY_ALARM_O <= OPT_I.battery_check &&
        CHARGE_PCT_I <= CHARGE_ALARM_PCT;
      HALF_CURRENT_O <= OPT_I.battery_check &&
        CHARGE_PCT_I <= CHARGE_ALARM_PCT;
      BRAKING_ON_O <= !pump && ACCEL_RELEASED_I &&
        sync2_ff.brake_sw;
      BRAKE_LEVEL_O <= (ACCEL_RELEASED_I && sync2_ff.brake_sw) ?
        lvl_c : '0;
      THERMAL_SWITCH_USE_O <= OPT_I.temp_sel == TOC_TEMP_DIGITAL &&
        sync2_ff.motor_thermal_input;
      THERMAL_ANALOG_USE_O <= OPT_I.temp_sel == TOC_TEMP_ANALOG;
      MAX_TORQUE_O <= !pump && OPT_I.aux_function;
      BUS_FAILURE_WARNING_O <= !pump && OPT_I.check_pump &&
        !PUMP_MSG_SEEN_I;
      // Pump alarm caps speed silently; only lost messages warn
      SPEED_LIMIT_PCT_O <= (!pump && OPT_I.check_pump &&
        (!PUMP_MSG_SEEN_I || PUMP_ALARM_I)) ? SPEED_CAP_PCT :
        SPEED_FULL_PCT;
    end
  end

  assign HOURS_O = hours_ff;
  assign BRAKE_POT_MIN_O = pmin_ff;
  assign RAMP_HOLD_O = ramp_ff == TOC_RAMP_HOLD;

  // ==========================================================================
  // Assertions
  a_safety_coil: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I) !sync2_ff.safety_tied_low |=> !MAIN_COIL_EN_O)
    else $error("coil enabled with safety open");
  a_pump_mode: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I) $rose(pump) |=> PUMP_MODE_O)
    else $error("pump mode not shown");
  a_speed_cap: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I) BUS_FAILURE_WARNING_O |->
    SPEED_LIMIT_PCT_O == SPEED_CAP_PCT)
    else $error("bus failure without speed cap");
  a_batt_alarm: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I) BATTERY_ALARM_O |-> $past(OPT_I.battery_check))
    else $error("alarm with check disabled");
  a_hours_run: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I) (!OPT_I.count_key_on && MOVING_I) |=>
    HOURS_O == $past(HOURS_O) + 32'h1)
    else $error("hours did not advance");
  a_excl_steer: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I) (!pump && OPT_I.aux_sel == TOC_AUX_EXCL &&
    !OPT_I.hydro_key_on && !excl_in) |=> !STEERING_CONTACTOR_O)
    else $error("exclusive steering without input");
  a_cal_min: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I) (CAL_BRAKE_MIN_I && sync2_ff.brake_sw) |=>
    BRAKE_POT_MIN_O == $past(BRAKE_POT_I))
    else $error("brake minimum not stored");
  a_digital_lvl: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I) (!OPT_I.pedal_analog && ACCEL_RELEASED_I &&
    sync2_ff.brake_sw) |=> BRAKE_LEVEL_O == $past(PEDAL_BRAKE_LVL_I))
    else $error("digital brake level wrong");
  a_ramp_hold: assert property (@(posedge CORE_CLK_I)
    disable iff (!RESET_N_I) (RAMP_HOLD_O && rcnt_ff != '0 && ON_SLOPE_I &&
    OPT_I.stop_on_ramp) |=> RAMP_HOLD_O)
    else $error("ramp hold ended early");

  c_ramp_done: cover property (@(posedge CORE_CLK_I) disable iff
    (!RESET_N_I) ramp_ff == TOC_RAMP_HOLD ##1 ramp_ff == TOC_RAMP_DONE);
  c_bus_fail: cover property (@(posedge CORE_CLK_I) disable iff
    (!RESET_N_I) $rose(BUS_FAILURE_WARNING_O));
  c_batt: cover property (@(posedge CORE_CLK_I) disable iff
    (!RESET_N_I) $rose(HALF_CURRENT_O));
  c_pump: cover property (@(posedge CORE_CLK_I) disable iff
    (!RESET_N_I) PUMP_MODE_O && LIFT_PERMIT_O);
  c_excl_steer: cover property (@(posedge CORE_CLK_I) disable iff
    (!RESET_N_I) excl_in ##1 STEERING_CONTACTOR_O);

endmodule : toc_core
`default_nettype wire

// >>> test/toc_truck_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Switch bank, pedals and pump inverter stand-in
module toc_truck_model (
  input wire logic clk_i,
  input wire toc_pkg::toc_pins_t sw_i,
  input wire logic link_up_i,
  input wire logic fault_i,
  output var toc_pkg::toc_pins_t pins_o,
  output logic msg_seen_o,
  output logic alarm_o
);
  import toc_pkg::*;
  // Contacts settle one edge after the operator moves them
  always_ff @(posedge clk_i) begin
    pins_o <= sw_i;
    // A silent link carries no alarm either, as on the real bus
    msg_seen_o <= link_up_i;
    alarm_o <= fault_i & link_up_i;
  end
endmodule : toc_truck_model
`default_nettype wire

// >>> test/truck_option_control_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module truck_option_control_logic_tb;
  import toc_pkg::*;
  logic clk, rst_n, moving, slope, accel_rel, cal, link_up, fault, seen, palm;
  toc_pins_t sw, pins;
  toc_opt_t opt;
  logic [15:0] aux_time;
  logic [7:0] pot, pot_max, rel_lvl, ped_lvl, brk_lvl, pot_min;
  logic [6:0] charge, limit;
  logic pump, coil, sgp, aux_ls, steer, steer_can, lift, sred, hbrk, acc_en;
  logic alarm, half, hold, brk_on, th_sw, th_an, maxtq, warn;
  logic [3:0] spd;
  logic [31:0] hours, h0;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;

  // ==========================================================================
  // Clock and instances
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  toc_truck_model MODEL (.clk_i(clk), .sw_i(sw), .link_up_i(link_up),
    .fault_i(fault), .pins_o(pins), .msg_seen_o(seen), .alarm_o(palm));

  toc_core #(.AUX_TIME_W(16)) DUT (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
    .PINS_I(pins), .OPT_I(opt), .AUX_TIME_I(aux_time), .MOVING_I(moving),
    .ON_SLOPE_I(slope), .ACCEL_RELEASED_I(accel_rel), .BRAKE_POT_I(pot),
    .BRAKE_POT_MAX_I(pot_max), .RELEASE_BRAKE_LVL_I(rel_lvl),
    .PEDAL_BRAKE_LVL_I(ped_lvl), .CHARGE_PCT_I(charge),
    .CAL_BRAKE_MIN_I(cal), .PUMP_MSG_SEEN_I(seen), .PUMP_ALARM_I(palm),
    .PUMP_MODE_O(pump), .MAIN_COIL_EN_O(coil), .SAFETY_GP_O(sgp),
    .AUX_LOW_SIDE_O(aux_ls), .STEERING_CONTACTOR_O(steer),
    .STEER_REQ_CAN_O(steer_can), .LIFT_PERMIT_O(lift), .SPEED_STEP_O(spd),
    .SPEED_REDUCE_O(sred), .HANDBRAKE_O(hbrk), .ACCEL_ENABLE_O(acc_en),
    .HOURS_O(hours), .BATTERY_ALARM_O(alarm), .HALF_CURRENT_O(half),
    .RAMP_HOLD_O(hold), .BRAKING_ON_O(brk_on), .BRAKE_LEVEL_O(brk_lvl),
    .BRAKE_POT_MIN_O(pot_min), .THERMAL_SWITCH_USE_O(th_sw),
    .THERMAL_ANALOG_USE_O(th_an), .MAX_TORQUE_O(maxtq),
    .BUS_FAILURE_WARNING_O(warn), .SPEED_LIMIT_PCT_O(limit));

  // ==========================================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Whole run is under 200 cycles; far above that means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Sequence
  initial begin
    sw = '0;
    opt = '0;
    aux_time = 16'h0006;
    {moving, slope, accel_rel, cal, fault, rst_n} = 6'h00;
    link_up = 1'b1;
    {pot, pot_max, rel_lvl, ped_lvl} = 32'h00A0_1090;
    charge = 7'h64;
    tick(3);
    chk(limit, 32'h64);
    rst_n <= 1'b1;
    sw.mode_tied_low <= 1'b1;
    sw.safety_tied_low <= 1'b1;
    sw.lift_permit_input <= 1'b1;
    sw.speed_step_request <= 4'h5;
    sw.steer_req <= 1'b1;
    tick(6);
    chk(pump, 32'h1);
    chk({lift, spd}, 32'h15);
    chk(sred, 32'h1);
    chk({steer, steer_can}, 32'h2);
    chk(aux_ls, 32'h1);
    opt.combi_system <= 1'b1;
    sw.safety_tied_low <= 1'b0;
    tick(6);
    chk({aux_ls, coil, sgp}, 32'h0);
    sw <= '0;
    opt <= '0;
    tick(1);
    sw.safety_tied_low <= 1'b1;
    opt.cutback_present <= 1'b1;
    tick(6);
    chk(pump, 32'h0);
    chk({sgp, sred, hbrk}, 32'h6);
    opt.cutback_present <= 1'b0;
    opt.enable_present <= 1'b1;
    sw.shared_e14 <= 1'b1;
    tick(6);
    chk({sred, hbrk, acc_en}, 32'h3);
    opt.enable_present <= 1'b0;
    opt.aux_sel <= TOC_AUX_EXCL;
    tick(3);
    chk({acc_en, steer}, 32'h3);
    sw.shared_e14 <= 1'b0;
    opt.aux_sel <= TOC_AUX_HYDRO;
    sw.fwd <= 1'b1;
    tick(6);
    chk({steer, steer_can}, 32'h3);
    sw.fwd <= 1'b0;
    tick(6);
    chk(steer, 32'h0);
    moving <= 1'b1;
    tick(3);
    chk(steer, 32'h1);
    moving <= 1'b0;
    opt.hydro_key_on <= 1'b1;
    sw.key_closed <= 1'b1;
    tick(6);
    chk(steer, 32'h1);
    opt.aux_sel <= TOC_AUX_BRAKE;
    moving <= 1'b1;
    tick(3);
    chk({aux_ls, steer}, 32'h2);
    sw.key_closed <= 1'b0;
    opt.hydro_key_on <= 1'b0;
    tick(6);
    h0 = hours;
    tick(8);
    chk(hours - h0, 32'h8);
    moving <= 1'b0;
    tick(2);
    h0 = hours;
    tick(5);
    chk(hours - h0, 32'h0);
    opt.count_key_on <= 1'b1;
    sw.key_closed <= 1'b1;
    tick(6);
    h0 = hours;
    tick(8);
    chk(hours - h0, 32'h8);
    opt.battery_check <= 1'b1;
    charge <= 7'h0A;
    tick(3);
    chk({alarm, half}, 32'h3);
    charge <= 7'h0B;
    tick(3);
    chk({alarm, half}, 32'h0);
    opt.battery_check <= 1'b0;
    charge <= 7'h05;
    tick(3);
    chk(alarm, 32'h0);
    sw.brake_sw <= 1'b1;
    accel_rel <= 1'b1;
    tick(6);
    chk({brk_on, brk_lvl}, 32'h190);
    opt.pedal_analog <= 1'b1;
    pot <= 8'h20;
    cal <= 1'b1;
    tick(3);
    cal <= 1'b0;
    tick(2);
    chk(pot_min, 32'h20);
    for (int i = 0; i < 3; i++) begin
      pot <= 8'h20 + 8'(i * 64);
      tick(3);
      chk(brk_lvl, 32'h10 + 32'(i * 64));
    end
    // Store is refused while the pedal switch is open
    // Let the open switch settle through the synchronisers first
    sw.brake_sw <= 1'b0;
    sw.motor_thermal_input <= 1'b1;
    tick(4);
    cal <= 1'b1;
    pot <= 8'h33;
    tick(3);
    chk({brk_on, pot_min}, 32'h020);
    cal <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      opt.temp_sel <= toc_temp_t'(i);
      tick(3);
      chk({th_sw, th_an}, {30'h0, i == 0, i == 1});
    end
    opt.aux_function <= 1'b1;
    opt.check_pump <= 1'b1;
    link_up <= 1'b0;
    tick(4);
    chk(maxtq, 32'h1);
    chk({warn, limit}, 32'h8A);
    link_up <= 1'b1;
    fault <= 1'b1;
    tick(4);
    chk({warn, limit}, 32'h0A);
    fault <= 1'b0;
    tick(4);
    chk(limit, 32'h64);
    opt.stop_on_ramp <= 1'b1;
    slope <= 1'b1;
    tick(7);
    chk(hold, 32'h1);
    tick(3);
    chk(hold, 32'h0);
    report_and_stop();
  end
endmodule : truck_option_control_logic_tb
`default_nettype wire
